//--- dv/hwcl_host_model.sv
module hwcl_host_model (
    input wire logic clk_sys,
    input wire logic [7:0] rd_data,
    output logic serial_chip_select_n,
    output logic wr_en,
    output logic [6:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_en,
    output logic [6:0] rd_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        serial_chip_select_n = 1'b1;
        {wr_en, rd_en, wr_addr, wr_data, rd_addr} = 24'h000000;
    end
    task frame_begin;
        @(posedge clk_sys);
        #1 serial_chip_select_n = 1'b0;
    endtask : frame_begin
    task write_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 {wr_en, wr_addr, wr_data} = {1'b1, a, d};
        @(posedge clk_sys);
        // Released data shows inverse, not last value
        #1 {wr_en, wr_data} = {1'b0, ~d};
    endtask : write_reg
    task frame_end;
        @(posedge clk_sys);
        #1 serial_chip_select_n = 1'b1;
        @(posedge clk_sys);
        #1;
    endtask : frame_end
    task wr1(input logic [6:0] a, input logic [7:0] d);
        frame_begin;
        write_reg(a, d);
        frame_end;
    endtask : wr1
    task read_reg(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1 {rd_en, rd_addr} = {1'b1, a};
        @(posedge clk_sys);
        #1 {rd_en, rd_addr} = {1'b0, ~a};
        d = rd_data;
    endtask : read_reg
endmodule : hwcl_host_model

//--- dv/hwcl_props.sv
module hwcl_props
    import hwcl_pkg::*;
#(
    parameter int TICK_CYCLES = 4,
    parameter int EXT_MS = 4
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic serial_chip_select_n,
    input wire logic rd_en,
    input wire logic [6:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic soft_reset,
    input wire logic reset_delay_start,
    input wire logic reset_hysteresis_select,
    input wire logic thermal_wait_extend_select,
    input wire logic reset_delay_select,
    input wire logic reset_delay_busy,
    input wire logic reset_delay_powerup,
    input wire logic thermal_wait_busy,
    input wire logic thermal_wait_extended,
    input wire logic [2:0] pump_switch_freq_sel,
    input wire logic peak_current_threshold_sel,
    input wire logic [1:0] spread_modulation_freq_sel,
    input wire logic pump_gpio_locked,
    input wire logic config_lock_active
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    int busy_n;
    logic [5:0] cfg;
    assign cfg = {pump_switch_freq_sel, peak_current_threshold_sel,
        spread_modulation_freq_sel};
    // Length of the running reset delay
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            busy_n <= 0;
        else
            busy_n <= reset_delay_busy ? busy_n + 1 : 0;
    end
    chk_first_reserved: assert property (
        rd_en && rd_addr == FIRST_OFFSET |=> (rd_data & ~FIRST_IMPL) == 8'h00)
        else $error("reserved first bits read nonzero");
    chk_second_read: assert property (
        rd_en && rd_addr == SECOND_OFFSET |=>
        rd_data == {$past(cfg), 1'b0, $past(config_lock_active)})
        else $error("second register read mismatch");
    chk_frame_hold: assert property (
        !serial_chip_select_n && !soft_reset |=> $stable(cfg))
        else $error("setting changed inside frame");
    chk_lock_at_rise: assert property (
        $rose(config_lock_active) |-> $past(serial_chip_select_n)
        && !$past(serial_chip_select_n, 2))
        else $error("lock not taken at chip-select rise");
    chk_lock_freeze: assert property (
        config_lock_active |=> config_lock_active && $stable({cfg,
        reset_hysteresis_select, thermal_wait_extend_select,
        reset_delay_select}))
        else $error("locked field changed");
    chk_soft_clear: assert property (
        soft_reset && !config_lock_active |=> pump_switch_freq_sel == PUMP_2M2
        && !pump_gpio_locked && !reset_hysteresis_select
        && !reset_delay_select)
        else $error("soft reset values wrong");
    chk_ext_first: assert property (
        reset_delay_start && !reset_delay_busy && reset_delay_powerup
        |=> reset_delay_busy [*8])
        else $error("first delay too short");
    chk_red_short: assert property (
        reset_delay_start && !reset_delay_busy && !reset_delay_powerup
        && reset_delay_select |=> ##[1:12] !reset_delay_busy)
        else $error("reduced delay too long");
    chk_delay_max: assert property (
        $fell(reset_delay_busy) |-> busy_n <= EXT_MS * TICK_CYCLES + 1)
        else $error("reset delay too long");
    chk_wait_plain: assert property (
        $rose(thermal_wait_busy) && !thermal_wait_extend_select
        |-> !thermal_wait_extended)
        else $error("extended wait while not selected");
    cover property ($rose(config_lock_active));
    cover property ($rose(thermal_wait_extended));
    cover property (soft_reset && config_lock_active);
endmodule : hwcl_props

bind hwcl_top hwcl_props #(.TICK_CYCLES(TICK_CYCLES), .EXT_MS(EXT_MS))
    hwcl_props_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .serial_chip_select_n(serial_chip_select_n), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .soft_reset(soft_reset),
    .reset_delay_start(reset_delay_start),
    .reset_hysteresis_select(reset_hysteresis_select),
    .thermal_wait_extend_select(thermal_wait_extend_select),
    .reset_delay_select(reset_delay_select),
    .reset_delay_busy(reset_delay_busy),
    .reset_delay_powerup(reset_delay_powerup),
    .thermal_wait_busy(thermal_wait_busy),
    .thermal_wait_extended(thermal_wait_extended),
    .pump_switch_freq_sel(pump_switch_freq_sel),
    .peak_current_threshold_sel(peak_current_threshold_sel),
    .spread_modulation_freq_sel(spread_modulation_freq_sel),
    .pump_gpio_locked(pump_gpio_locked),
    .config_lock_active(config_lock_active));

//--- dv/hwcl_top_tb.sv
module hwcl_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import hwcl_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic soft_reset = 1'b0, therm = 1'b0, tclr = 1'b0, dstart = 1'b0;
    logic cs_n, wr_en, rd_en, hys, tw, dsel, dbusy, dpow, tbusy, text;
    logic peak, l0, l1;
    logic [6:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data;
    logic [2:0] pump;
    logic [1:0] spread;
    int fails = 0;
    int compares = 0;
    always #2 clk_sys = ~clk_sys;
    hwcl_host_model hwcl_host_model_inst (.clk_sys(clk_sys),
        .rd_data(rd_data), .serial_chip_select_n(cs_n), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
        .rd_addr(rd_addr));
    hwcl_top #(.TICK_CYCLES(4), .WAIT_MS(3), .EXT_MS(4), .RED_MS(2))
        hwcl_top_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .serial_chip_select_n(cs_n), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .soft_reset(soft_reset),
        .second_level_thermal_shutdown(therm), .thermal_count_clear(tclr),
        .reset_delay_start(dstart), .reset_hysteresis_select(hys),
        .thermal_wait_extend_select(tw), .reset_delay_select(dsel),
        .reset_delay_busy(dbusy), .reset_delay_powerup(dpow),
        .thermal_wait_busy(tbusy), .thermal_wait_extended(text),
        .pump_switch_freq_sel(pump), .peak_current_threshold_sel(peak),
        .spread_modulation_freq_sel(spread), .pump_gpio_locked(l0),
        .config_lock_active(l1));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task finish_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        hwcl_host_model_inst.read_reg(a, d);
        check(d, e);
    endtask : rd
    // Select 0 pulses soft reset, 1 clears the event count
    task strobe(input int k);
        @(posedge clk_sys);
        #1 {soft_reset, tclr} = (k == 0) ? 2'b10 : 2'b01;
        @(posedge clk_sys);
        #1 {soft_reset, tclr} = 2'b00;
    endtask : strobe
    task run_delay(output int c);
        @(posedge clk_sys);
        #1 dstart = 1'b1;
        @(posedge clk_sys);
        #1 dstart = 1'b0;
        for (c = 1; c < 1000 && dbusy === 1'b1; c++)
            @(posedge clk_sys);
    endtask : run_delay
    task ev(output logic x);
        int k;
        @(posedge clk_sys);
        #1 therm = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 therm = 1'b0;
        x = text;
        for (k = 0; k < 1000 && tbusy === 1'b1; k++)
            @(posedge clk_sys);
    endtask : ev
    initial begin
        #100000;
        fails++;
        finish_test;
    end
    initial begin
        logic [7:0] d;
        logic x;
        int i, n, m;
        repeat (2) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        rd(FIRST_OFFSET, FIRST_POR);
        rd(SECOND_OFFSET, SECOND_POR);
        rd(7'h10, 8'h00);
        hwcl_host_model_inst.frame_begin;
        hwcl_host_model_inst.write_reg(FIRST_OFFSET, 8'hFF);
        rd(FIRST_OFFSET, 8'h00);
        hwcl_host_model_inst.frame_end;
        rd(FIRST_OFFSET, FIRST_IMPL);
        check({hys, tw, dsel, l0}, 8'h0F);
        for (i = 0; i < 8; i++) begin
            d = {i[2:0], i[0], i[1:0], 2'b10};
            hwcl_host_model_inst.wr1(SECOND_OFFSET, d);
            rd(SECOND_OFFSET, d & 8'hFC);
            check({pump, peak, spread}, d[7:2]);
        end
        check(dpow, 1'b1);
        run_delay(n);
        check(dpow, 1'b0);
        run_delay(m);
        check(n > m, 1'b1);
        hwcl_host_model_inst.wr1(FIRST_OFFSET, 8'hB0);
        check(l0, 1'b0);
        strobe(1);
        for (i = 0; i < 18; i++) begin
            ev(x);
            check(x, i >= 16);
        end
        hwcl_host_model_inst.wr1(FIRST_OFFSET, 8'h90);
        ev(x);
        check(x, 1'b0);
        hwcl_host_model_inst.wr1(FIRST_OFFSET, 8'hB8);
        strobe(0);
        rd(FIRST_OFFSET, FIRST_POR);
        rd(SECOND_OFFSET, SECOND_POR);
        hwcl_host_model_inst.frame_begin;
        hwcl_host_model_inst.write_reg(FIRST_OFFSET, 8'h98);
        hwcl_host_model_inst.write_reg(SECOND_OFFSET, 8'h2D);
        check(l1, 1'b0);
        hwcl_host_model_inst.frame_end;
        check(l1, 1'b1);
        hwcl_host_model_inst.frame_begin;
        hwcl_host_model_inst.write_reg(SECOND_OFFSET, 8'hC0);
        hwcl_host_model_inst.write_reg(FIRST_OFFSET, 8'h00);
        hwcl_host_model_inst.frame_end;
        rd(FIRST_OFFSET, 8'h90);
        rd(SECOND_OFFSET, 8'h2D);
        hwcl_host_model_inst.wr1(FIRST_OFFSET, 8'h08);
        rd(FIRST_OFFSET, 8'h98);
        strobe(0);
        rd(FIRST_OFFSET, 8'h90);
        rd(SECOND_OFFSET, 8'h2D);
        @(posedge clk_sys);
        #1 reset_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        rd(SECOND_OFFSET, SECOND_POR);
        finish_test;
    end
endmodule : hwcl_top_tb

//--- logic/hwcl_pkg.sv
package hwcl_pkg;
    // Register offsets on the serial interface (7-bit addresses)
    localparam logic [6:0] FIRST_OFFSET = 7'h0E;
    localparam logic [6:0] SECOND_OFFSET = 7'h0F;

    // First control register field positions
    localparam int RST_HYS_BIT = 7;
    localparam int THERM_WAIT_BIT = 5;
    localparam int RST_DELAY_BIT = 4;
    localparam int LOCK0_BIT = 3;

    // Second control register field positions
    localparam int PUMP_FREQ_MSB = 7;
    localparam int PUMP_FREQ_LSB = 5;
    localparam int PEAK_BIT = 4;
    localparam int SPREAD_MSB = 3;
    localparam int SPREAD_LSB = 2;
    localparam int LOCK1_BIT = 0;

    // Power-up values
    localparam logic [7:0] FIRST_POR = 8'h00;
    localparam logic [7:0] SECOND_POR = 8'h40;

    // Implemented bits; all others are reserved and read zero
    localparam logic [7:0] FIRST_IMPL = 8'hB8;
    localparam logic [7:0] SECOND_IMPL = 8'hFD;
    // Fields frozen by the level-1 lock
    localparam logic [7:0] FIRST_LOCK1_MASK = 8'hB0;
    localparam logic [7:0] SECOND_LOCK1_MASK = 8'hFD;

    // Pump switching frequency codes
    localparam logic [2:0] PUMP_1M8 = 3'h0;
    localparam logic [2:0] PUMP_2M0 = 3'h1;
    localparam logic [2:0] PUMP_2M2 = 3'h2;
    localparam logic [2:0] PUMP_2M4 = 3'h3;

    // Spread modulation codes
    localparam logic [1:0] SPREAD_OFF = 2'h0;
    localparam logic [1:0] SPREAD_15K625 = 2'h1;
    localparam logic [1:0] SPREAD_31K250 = 2'h2;
    localparam logic [1:0] SPREAD_62K500 = 2'h3;

    // Timing
    localparam int CLK_HZ = 250000000;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_TIME_US;
    localparam int THERM_WAIT_S = 1;
    localparam int THERM_WAIT_MS = THERM_WAIT_S * 1000;
    localparam int THERM_EXTEND_FACTOR = 64;
    localparam int THERM_EVENT_LIMIT = 16;
    localparam int EXT_DELAY_MS = 10;
    localparam int RED_DELAY_MS = 2;
endpackage : hwcl_pkg

//--- logic/hwcl_reset_delay.sv
module hwcl_reset_delay #(
    parameter int EXT_MS = hwcl_pkg::EXT_DELAY_MS,
    parameter int RED_MS = hwcl_pkg::RED_DELAY_MS
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ms_tick,
    input wire logic start,
    input wire logic reduced_sel,
    output logic busy,
    output logic powerup_pending
);
    import hwcl_pkg::*;

    typedef enum logic {HWCL_IDLE, HWCL_COUNT} hwcl_dly_state_type;

    localparam int CW = $clog2(EXT_MS + RED_MS + 1);

    hwcl_dly_state_type state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic pwr_q, pwr_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        pwr_d = pwr_q;
        case (state_q)
            HWCL_IDLE: begin
                if (start) begin
                    state_d = HWCL_COUNT;
                    // First delay after power-up always extended
                    if (reduced_sel && !pwr_q) begin
                        cnt_d = CW'(RED_MS);
                    end else begin
                        cnt_d = CW'(EXT_MS);
                    end
                end
            end
            HWCL_COUNT: begin
                if (ms_tick) begin
                    if (cnt_q <= CW'(1)) begin
                        state_d = HWCL_IDLE;
                        cnt_d = '0;
                        pwr_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q - CW'(1);
                    end
                end
            end
            default: begin
                state_d = HWCL_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= HWCL_IDLE;
            cnt_q <= '0;
            pwr_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pwr_q <= pwr_d;
        end
    end

    assign busy = (state_q == HWCL_COUNT);
    assign powerup_pending = pwr_q;
endmodule : hwcl_reset_delay

//--- logic/hwcl_top.sv
// Function
// - Hysteresis bit 1 releases undervoltage reset at highest threshold.
// - Reserved bits 6, 2:0 of first and 1 of second read zero.
// - Thermal wait bit 0: second-level shutdown release waits 1s always.
// - Thermal wait bit 1: 1s wait, times 64 after over 16 events.
// - First register bit 4 picks reduced (1) or extended (0) reset delay.
// - Level-0 lock set blocks pump enable and GPIO configuration changes.
// - Soft reset keeps the bits protected by a set level-1 lock unchanged.
// - Second register bits 7:5 pick pump frequency, default code 010.
// - Second register bit 4 picks low or high peak current threshold.
// - Second register bits 3:2 pick spread modulation frequency or off.
// - Level-1 lock freezes all other lockable fields until power-up.
// - Level-1 locking takes effect at next chip-select rising edge.
// - Active level-1 lock bit is unwritable; only power-on reset clears it.
// - Power-up uses extended delay; later restarts use configured delay.
// - Serial writes become active when chip-select returns high.
module hwcl_top #(
    parameter int TICK_CYCLES = hwcl_pkg::TICK_CYCLES,
    parameter int WAIT_MS = hwcl_pkg::THERM_WAIT_MS,
    parameter int EXT_MS = hwcl_pkg::EXT_DELAY_MS,
    parameter int RED_MS = hwcl_pkg::RED_DELAY_MS
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic serial_chip_select_n,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic soft_reset,
    input wire logic second_level_thermal_shutdown,
    input wire logic thermal_count_clear,
    input wire logic reset_delay_start,
    output logic reset_hysteresis_select,
    output logic thermal_wait_extend_select,
    output logic reset_delay_select,
    output logic reset_delay_busy,
    output logic reset_delay_powerup,
    output logic thermal_wait_busy,
    output logic thermal_wait_extended,
    output logic [2:0] pump_switch_freq_sel,
    output logic peak_current_threshold_sel,
    output logic [1:0] spread_modulation_freq_sel,
    output logic pump_gpio_locked,
    output logic config_lock_active
);
    import hwcl_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);

    function automatic logic [7:0] merge_write(
        input logic [7:0] cur,
        input logic [7:0] wdat,
        input logic [7:0] wmask
    );
        merge_write = (cur & ~wmask) | (wdat & wmask);
    endfunction : merge_write

    logic [7:0] first_q, first_d;
    logic [7:0] second_q, second_d;
    logic [7:0] pend1_q, pend1_d;
    logic [7:0] pend2_q, pend2_d;
    logic pv1_q, pv1_d;
    logic pv2_q, pv2_d;
    logic cs_q, cs_d;
    logic [7:0] rd_q, rd_d;
    logic [TW-1:0] tick_q, tick_d;
    logic tsd_q, tsd_d;
    logic cs_rise;
    logic ms_tick;
    logic lock1;
    logic [7:0] mask1;
    logic [7:0] mask2;

    hwcl_tsd_if tsd_bus ();

    assign cs_rise = serial_chip_select_n && !cs_q;
    assign lock1 = second_q[LOCK1_BIT];
    assign ms_tick = (tick_q == '0);

    // Writable masks; level-1 lock removes its fields, lock bit included
    always_comb begin
        mask1 = FIRST_IMPL;
        mask2 = SECOND_IMPL;
        if (lock1) begin
            mask1 = FIRST_IMPL & ~FIRST_LOCK1_MASK;
            mask2 = SECOND_IMPL & ~SECOND_LOCK1_MASK;
        end
    end

    // Register state: pending shadows, commit at chip-select rise
    always_comb begin
        first_d = first_q;
        second_d = second_q;
        pend1_d = pend1_q;
        pend2_d = pend2_q;
        pv1_d = pv1_q;
        pv2_d = pv2_q;
        cs_d = serial_chip_select_n;
        if (soft_reset) begin
            pv1_d = 1'b0;
            pv2_d = 1'b0;
            if (lock1) begin
                first_d = first_q & FIRST_LOCK1_MASK;
                second_d = second_q;
            end else begin
                first_d = FIRST_POR;
                second_d = SECOND_POR;
            end
        end else begin
            if (wr_en && wr_addr == FIRST_OFFSET) begin
                pend1_d = wr_data;
                pv1_d = 1'b1;
            end
            if (wr_en && wr_addr == SECOND_OFFSET) begin
                pend2_d = wr_data;
                pv2_d = 1'b1;
            end
            if (cs_rise) begin
                if (pv1_d) begin
                    first_d = merge_write(first_q, pend1_d, mask1);
                end
                if (pv2_d) begin
                    second_d = merge_write(second_q, pend2_d, mask2);
                end
                pv1_d = 1'b0;
                pv2_d = 1'b0;
            end
        end
        first_d = first_d & FIRST_IMPL;
        second_d = second_d & SECOND_IMPL;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            first_q <= FIRST_POR;
            second_q <= SECOND_POR;
            pend1_q <= 8'h00;
            pend2_q <= 8'h00;
            pv1_q <= 1'b0;
            pv2_q <= 1'b0;
            cs_q <= 1'b1;
        end else begin
            first_q <= first_d;
            second_q <= second_d;
            pend1_q <= pend1_d;
            pend2_q <= pend2_d;
            pv1_q <= pv1_d;
            pv2_q <= pv2_d;
            cs_q <= cs_d;
        end
    end

    // Readback of committed values
    always_comb begin
        rd_d = rd_q;
        if (rd_en) begin
            case (rd_addr)
                FIRST_OFFSET: rd_d = first_q & FIRST_IMPL;
                SECOND_OFFSET: rd_d = second_q & SECOND_IMPL;
                default: rd_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= rd_d;
        end
    end

    // Millisecond tick divider and thermal event edge
    always_comb begin
        tick_d = ms_tick ? TW'(TICK_CYCLES - 1) : tick_q - TW'(1);
        tsd_d = second_level_thermal_shutdown;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tick_q <= '0;
            tsd_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            tsd_q <= tsd_d;
        end
    end

    assign tsd_bus.ms_tick = ms_tick;
    assign tsd_bus.event_start = second_level_thermal_shutdown && !tsd_q;
    assign tsd_bus.count_clear = thermal_count_clear;
    assign tsd_bus.extend_sel = first_q[THERM_WAIT_BIT];

    hwcl_tsd_wait #(
        .WAIT_MS(WAIT_MS)
    ) u_tsd_wait (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .tif(tsd_bus)
    );

    hwcl_reset_delay #(
        .EXT_MS(EXT_MS),
        .RED_MS(RED_MS)
    ) u_reset_delay (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ms_tick(ms_tick),
        .start(reset_delay_start),
        .reduced_sel(first_q[RST_DELAY_BIT]),
        .busy(reset_delay_busy),
        .powerup_pending(reset_delay_powerup)
    );

    assign thermal_wait_busy = tsd_bus.wait_busy;
    assign thermal_wait_extended = tsd_bus.wait_extended;
    assign reset_hysteresis_select = first_q[RST_HYS_BIT];
    assign thermal_wait_extend_select = first_q[THERM_WAIT_BIT];
    assign reset_delay_select = first_q[RST_DELAY_BIT];
    assign pump_switch_freq_sel =
        second_q[PUMP_FREQ_MSB:PUMP_FREQ_LSB];
    assign peak_current_threshold_sel = second_q[PEAK_BIT];
    assign spread_modulation_freq_sel =
        second_q[SPREAD_MSB:SPREAD_LSB];
    // Other registers gate pump enable and GPIO writes on this level
    assign pump_gpio_locked = first_q[LOCK0_BIT];
    assign config_lock_active = lock1;
    assign rd_data = rd_q;
endmodule : hwcl_top

//--- logic/hwcl_tsd_if.sv
interface hwcl_tsd_if;
    logic ms_tick;
    logic event_start;
    logic count_clear;
    logic extend_sel;
    logic wait_busy;
    logic wait_extended;

    modport ctrl (
        output ms_tick,
        output event_start,
        output count_clear,
        output extend_sel,
        input wait_busy,
        input wait_extended
    );
    modport timer (
        input ms_tick,
        input event_start,
        input count_clear,
        input extend_sel,
        output wait_busy,
        output wait_extended
    );
endinterface : hwcl_tsd_if

//--- logic/hwcl_tsd_wait.sv
module hwcl_tsd_wait #(
    parameter int WAIT_MS = hwcl_pkg::THERM_WAIT_MS
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    hwcl_tsd_if.timer tif
);
    import hwcl_pkg::*;

    localparam int CW = $clog2(WAIT_MS * THERM_EXTEND_FACTOR + 1);
    localparam logic [CW-1:0] BASE = CW'(WAIT_MS);
    localparam logic [CW-1:0] LONG = CW'(WAIT_MS * THERM_EXTEND_FACTOR);
    localparam logic [4:0] LIMIT = 5'(THERM_EVENT_LIMIT);

    logic [4:0] events_q, events_d;
    logic [CW-1:0] wait_q, wait_d;
    logic ext_q, ext_d;

    always_comb begin
        events_d = events_q;
        wait_d = wait_q;
        ext_d = ext_q;
        if (tif.count_clear) begin
            events_d = 5'h00;
        end
        if (tif.event_start) begin
            if (events_d <= LIMIT) begin
                events_d = events_d + 5'h01;
            end
            if (tif.extend_sel && events_d > LIMIT) begin
                wait_d = LONG;
                ext_d = 1'b1;
            end else begin
                wait_d = BASE;
                ext_d = 1'b0;
            end
        end else if (tif.ms_tick && wait_q != '0) begin
            wait_d = wait_q - CW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            events_q <= 5'h00;
            wait_q <= '0;
            ext_q <= 1'b0;
        end else begin
            events_q <= events_d;
            wait_q <= wait_d;
            ext_q <= ext_d;
        end
    end

    assign tif.wait_busy = (wait_q != '0);
    assign tif.wait_extended = ext_q && (wait_q != '0);
endmodule : hwcl_tsd_wait
